// file: rtl/setup_save_recall_keys.v
// Overview of operation
// - save option 1 or 2 writes current configuration into slot 1 or 2.
// - calibrate option takes a volt value within -200 to +200, calibrates channel.
// - store-calibration writes selected channel's calibration constants permanently.
// - setups are kept per channel; save uses the channel selected beforehand.
// - a setup holds zero, filter, range, trigger, rate, size, math, coupling, address, format.
// - power-up and device clear restore setup slot 1.
// - recall 0 loads factory defaults, 1 loads slot 1, 2 loads slot 2.
// - as delivered both slots equal the factory default configuration.
// - key codes 1 to 38 act as button presses; 24 to 33 are digits.
// - key code matches the code reported in the machine status word.
// - multi-key sequences arrive as successive key commands, executed in order.
// - key code 9 is reserved for a scanner and does nothing; here no key press, but key code and status word still become 9.
// - commands are buffered and executed on the execute character; bus held off.
`timescale 1ns/1ps
`default_nettype none
`include "setup_keys_consts.vh"
module setup_save_recall_keys (
    input wire clk_in,
    input wire rst_b_in,
    input wire dev_clear_in,
    input wire cmd_valid_in,
    input wire [7:0] cmd_char_in,
    input wire hold_off_en_in,
    input wire channel_in,
    input wire [63:0] cur_cfg_in,
    input wire [31:0] cal_const_in,
    output wire cmd_ready_out,
    output wire bus_hold_off_out,
    output reg cfg_load_out,
    output reg [63:0] cfg_data_out,
    output reg cfg_channel_out,
    output reg cal_start_out,
    output reg [15:0] cal_volts_out,
    output reg cal_neg_out,
    output reg key_press_out,
    output reg [7:0] key_code_out,
    output reg key_digit_out,
    output reg [7:0] machine_status_word_out,
    output reg error_out
);
    localparam S_IDLE = 5'h01;
    localparam S_EXEC = 5'h02;
    localparam S_READ = 5'h04;
    localparam S_LOAD = 5'h08;
    localparam S_INIT = 5'h10;
    reg [4:0] state_q;
    reg [7:0] letter_q;
    reg [7:0] opt_q;
    reg [15:0] num_q;
    reg neg_q;
    reg in_num_q;
    reg have_opt_q;
    reg init_ch_q;
    reg ch_q;
    reg [1:0] slot_q;
    reg factory_q;
    reg wr_en;
    reg [2:0] wr_addr;
    reg [63:0] wr_data;
    wire [63:0] rd_data;
    wire is_digit;
    wire [7:0] dval;
    wire [15:0] num_next;
    assign is_digit = (cmd_char_in >= `CH_ZERO) && (cmd_char_in <= `CH_NINE);
    assign dval = cmd_char_in - `CH_ZERO;
    assign num_next = ((num_q << 3) + (num_q << 1)) + {8'h00, dval};
    // accept characters only while idle; hold the bus off during processing
    assign cmd_ready_out = (state_q == S_IDLE);
    assign bus_hold_off_out = hold_off_en_in && (state_q != S_IDLE);
    setup_nvram nvram_u (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wr_en_in(wr_en),
        .addr_in(wr_addr),
        .wr_data_in(wr_data),
        .rd_addr_in({ch_q, slot_q}),
        .rd_data_out(rd_data)
    );
    // save and calibration writes, decoded combinationally in the execute state
    always @* begin
        wr_en = 1'b0;
        wr_addr = {channel_in, 2'h0};
        wr_data = cur_cfg_in;
        if (state_q == S_EXEC && letter_q == `CH_SAVE && have_opt_q) begin
            if (opt_q == `OPT_SLOT1 || opt_q == `OPT_SLOT2) begin
                wr_en = 1'b1;
                wr_addr = {channel_in, opt_q[1:0]};
            end else if (opt_q == `OPT_CALSTORE) begin
                wr_en = 1'b1;
                wr_addr = {channel_in, `SLOT_CAL};
                wr_data = {32'h0000_0000, cal_const_in};
            end
        end
    end
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= S_INIT;
            letter_q <= 8'h00;
            opt_q <= 8'h00;
            num_q <= 16'h0000;
            neg_q <= 1'b0;
            in_num_q <= 1'b0;
            have_opt_q <= 1'b0;
            init_ch_q <= 1'b0;
            ch_q <= 1'b0;
            slot_q <= `SLOT_ONE;
            factory_q <= 1'b0;
            cfg_load_out <= 1'b0;
            cfg_data_out <= `FACTORY_CFG;
            cfg_channel_out <= 1'b0;
            cal_start_out <= 1'b0;
            cal_volts_out <= 16'h0000;
            cal_neg_out <= 1'b0;
            key_press_out <= 1'b0;
            key_code_out <= 8'h00;
            key_digit_out <= 1'b0;
            machine_status_word_out <= 8'h00;
            error_out <= 1'b0;
        end else begin
            cfg_load_out <= 1'b0;
            cal_start_out <= 1'b0;
            key_press_out <= 1'b0;
            if (dev_clear_in) begin
                // device clear drops the pending command and reloads slot 1
                state_q <= S_INIT;
                init_ch_q <= 1'b0;
                letter_q <= 8'h00;
                have_opt_q <= 1'b0;
                in_num_q <= 1'b0;
                error_out <= 1'b0;
            end else begin
                case (state_q)
                    S_INIT: begin
                        // restore slot 1 on each channel in turn
                        ch_q <= init_ch_q;
                        slot_q <= `SLOT_ONE;
                        factory_q <= 1'b0;
                        state_q <= S_READ;
                    end
                    S_IDLE: begin
                        if (cmd_valid_in) begin
                            if (cmd_char_in == `CH_EXEC) begin
                                state_q <= S_EXEC;
                            end else if (cmd_char_in == `CH_SAVE || cmd_char_in == `CH_RECALL
                                         || cmd_char_in == `CH_HIT) begin
                                letter_q <= cmd_char_in;
                                opt_q <= 8'h00;
                                num_q <= 16'h0000;
                                neg_q <= 1'b0;
                                in_num_q <= 1'b0;
                                have_opt_q <= 1'b0;
                            end else if (cmd_char_in == `CH_COMMA) begin
                                in_num_q <= 1'b1;
                            end else if (cmd_char_in == `CH_MINUS && in_num_q) begin
                                neg_q <= 1'b1;
                            end else if (is_digit && in_num_q) begin
                                // stop once past the limit so a long value cannot wrap
                                if (num_q <= `CAL_LIMIT) begin
                                    num_q <= num_next;
                                end
                            end else if (is_digit) begin
                                // long options saturate to an invalid code
                                if (opt_q > `OPT_ACC_MAX) begin
                                    opt_q <= `OPT_SAT;
                                end else begin
                                    opt_q <= ((opt_q << 3) + (opt_q << 1)) + dval;
                                end
                                have_opt_q <= 1'b1;
                            end
                        end
                    end
                    S_EXEC: begin
                        state_q <= S_IDLE;
                        have_opt_q <= 1'b0;
                        letter_q <= 8'h00;
                        in_num_q <= 1'b0;
                        if (have_opt_q && letter_q == `CH_SAVE) begin
                            if (opt_q == `OPT_CAL) begin
                                if (num_q <= `CAL_LIMIT) begin
                                    cal_start_out <= 1'b1;
                                    cal_volts_out <= num_q;
                                    cal_neg_out <= neg_q;
                                end else begin
                                    error_out <= 1'b1;
                                end
                            end else if (opt_q != `OPT_SLOT1 && opt_q != `OPT_SLOT2
                                         && opt_q != `OPT_CALSTORE) begin
                                error_out <= 1'b1;
                            end
                        end else if (have_opt_q && letter_q == `CH_RECALL) begin
                            // recall affects the selected channel only
                            if (opt_q == `OPT_DEFAULT) begin
                                cfg_load_out <= 1'b1;
                                cfg_data_out <= `FACTORY_CFG;
                                cfg_channel_out <= channel_in;
                            end else if (opt_q == `OPT_SLOT1 || opt_q == `OPT_SLOT2) begin
                                ch_q <= channel_in;
                                slot_q <= opt_q[1:0];
                                factory_q <= 1'b1;
                                state_q <= S_READ;
                            end else begin
                                error_out <= 1'b1;
                            end
                        end else if (have_opt_q && letter_q == `CH_HIT) begin
                            if (opt_q >= `KEY_MIN && opt_q <= `KEY_MAX) begin
                                // scan key accepted without a press; key code and status word still update
                                key_press_out <= (opt_q != `KEY_SCAN);
                                key_code_out <= opt_q;
                                key_digit_out <= (opt_q >= `KEY_DIGIT_LO)
                                    && (opt_q <= `KEY_DIGIT_HI);
                                machine_status_word_out <= opt_q;
                            end else begin
                                error_out <= 1'b1;
                            end
                        end else if (letter_q != 8'h00) begin
                            error_out <= 1'b1;
                        end
                    end
                    S_READ: begin
                        state_q <= S_LOAD;
                    end
                    S_LOAD: begin
                        cfg_load_out <= 1'b1;
                        cfg_data_out <= rd_data;
                        cfg_channel_out <= ch_q;
                        if (!factory_q && !init_ch_q) begin
                            init_ch_q <= 1'b1;
                            state_q <= S_INIT;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // setup_save_recall_keys
`default_nettype wire

// file: rtl/setup_keys_consts.vh
`ifndef SETUP_KEYS_CONSTS_VH
`define SETUP_KEYS_CONSTS_VH
// command letters and execute character
`define CH_SAVE 8'h4c
`define CH_RECALL 8'h41
`define CH_HIT 8'h48
`define CH_EXEC 8'h58
`define CH_COMMA 8'h2c
`define CH_MINUS 8'h2d
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_SPACE 8'h20
// command options
`define OPT_SLOT1 8'h01
`define OPT_SLOT2 8'h02
`define OPT_CAL 8'h04
`define OPT_CALSTORE 8'h05
`define OPT_DEFAULT 8'h00
// key code and calibration voltage limits
`define KEY_MIN 8'h01
`define KEY_MAX 8'h26
`define KEY_SCAN 8'h09
`define KEY_DIGIT_LO 8'h18
`define KEY_DIGIT_HI 8'h21
`define CAL_LIMIT 16'h00c8
// setup word and memory layout
`define CFG_W 64
`define CAL_W 32
`define CH_W 1
`define ADDR_W 3
`define SLOT_CAL 2'h3
`define FACTORY_CFG 64'h0000_0000_0000_0000
`define NUM_W 16
`define SLOT_ONE 2'h1
// option accumulator: beyond this value one more digit could wrap 8 bits
`define OPT_ACC_MAX 8'h18
`define OPT_SAT 8'hff
`endif

// file: rtl/setup_nvram.v
`timescale 1ns/1ps
`default_nettype none
`include "setup_keys_consts.vh"
// setup and calibration store, addressed by {channel, slot}
module setup_nvram (
    input wire clk_in,
    input wire rst_b_in,
    input wire wr_en_in,
    input wire [2:0] addr_in,
    input wire [63:0] wr_data_in,
    input wire [2:0] rd_addr_in,
    output reg [63:0] rd_data_out
);
    reg [63:0] mem_q [0:7];
    integer i;
    // every slot starts equal to the factory configuration
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 8; i = i + 1) begin
                mem_q[i] <= `FACTORY_CFG;
            end
            rd_data_out <= `FACTORY_CFG;
        end else begin
            if (wr_en_in) begin
                mem_q[addr_in] <= wr_data_in;
            end
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule // setup_nvram
`default_nettype wire

// file: bench/setup_save_recall_keys_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module setup_save_recall_keys_monitor (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_char_in,
    input wire logic hold_off_en_in,
    input wire logic dev_clear_in,
    input wire logic cmd_ready_out,
    input wire logic bus_hold_off_out,
    input wire logic cal_start_out,
    input wire logic [15:0] cal_volts_out,
    input wire logic key_press_out,
    input wire logic [7:0] key_code_out,
    input wire logic key_digit_out,
    input wire logic [7:0] machine_status_word_out,
    input wire logic error_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_exec;
        cmd_valid_in && cmd_ready_out && cmd_char_in == 8'h58;
    endsequence
    sequence s_press;
        key_press_out ##1 !key_press_out;
    endsequence
    property p_exec_busy;
        s_exec |=> !cmd_ready_out;
    endproperty
    property p_hold;
        bus_hold_off_out |-> hold_off_en_in && !cmd_ready_out;
    endproperty
    property p_cal_range;
        cal_start_out |-> cal_volts_out <= 16'h00c8;
    endproperty
    property p_key_range;
        key_press_out |-> key_code_out >= 8'h01 && key_code_out <= 8'h26 && key_code_out != 8'h09;
    endproperty
    property p_digit;
        key_press_out |-> key_digit_out == (key_code_out >= 8'h18 && key_code_out <= 8'h21);
    endproperty
    property p_msw;
        key_press_out |-> machine_status_word_out == key_code_out;
    endproperty
    property p_pulse;
        key_press_out |-> s_press;
    endproperty
    property p_err_sticky;
        error_out && !dev_clear_in |=> error_out;
    endproperty
    property p_hold_on;
        s_exec ##0 hold_off_en_in |=> bus_hold_off_out;
    endproperty
    a_exec_busy: assert property (p_exec_busy) else $error("ready high after execute");
    a_hold: assert property (p_hold) else $error("hold off while idle");
    a_cal_range: assert property (p_cal_range) else $error("volts over limit");
    a_key_range: assert property (p_key_range) else $error("bad key pressed");
    a_digit: assert property (p_digit) else $error("digit flag wrong");
    a_msw: assert property (p_msw) else $error("status word differs");
    a_pulse: assert property (p_pulse) else $error("key pulse too long");
    a_err_sticky: assert property (p_err_sticky) else $error("error dropped");
    a_hold_on: assert property (p_hold_on) else $error("no hold off after execute");
endmodule // setup_save_recall_keys_monitor
bind setup_save_recall_keys setup_save_recall_keys_monitor i_mon (.clk_in, .rst_b_in,
    .cmd_valid_in, .cmd_char_in, .hold_off_en_in, .dev_clear_in, .cmd_ready_out,
    .bus_hold_off_out, .cal_start_out, .cal_volts_out, .key_press_out, .key_code_out,
    .key_digit_out, .machine_status_word_out, .error_out);
`default_nettype wire

// file: bench/bus_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
    input wire logic clk_in,
    input wire logic cmd_ready_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_char_out
);
    logic rdy_s;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_char_out = 8'h00;
    end
    // ready is sampled mid-cycle so the edge decision is race free
    always @(negedge clk_in) rdy_s <= cmd_ready_in;
    // each char held until taken; commands go out in order
    task automatic send(input string s);
        int i;
        @(posedge clk_in);
        for (i = 0; i < s.len(); i++) begin
            cmd_valid_out <= 1'b1;
            cmd_char_out <= s[i];
            do @(posedge clk_in); while (rdy_s !== 1'b1);
        end
        cmd_valid_out <= 1'b0;
        cmd_char_out <= ~s[s.len()-1];
    endtask
endmodule // bus_ctrl_model
`default_nettype wire

// file: bench/setup_save_recall_keys_test.sv
`timescale 1ns/1ps
`default_nettype none
module setup_save_recall_keys_test;
    logic clk_in, rst_b_in, dev_clear_in, channel_in, hold_en;
    logic [31:0] cal_const_in;
    wire logic hold;
    logic [63:0] cur_cfg_in;
    wire logic valid, ready, cfg_load, cfg_ch, cal_start, cal_neg, key_press, key_digit, err;
    wire logic [63:0] cfg_data;
    wire logic [15:0] volts;
    wire logic [7:0] chr, key_code, msw;
    int n_cfg, n_cal, n_hold, compares, n_errors;
    logic [63:0] l_cfg;
    logic l_ch;
    logic [7:0] kq[$];
    setup_save_recall_keys i_setup_save_recall_keys (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .dev_clear_in(dev_clear_in), .cmd_valid_in(valid), .cmd_char_in(chr),
        .hold_off_en_in(hold_en), .channel_in(channel_in), .cur_cfg_in(cur_cfg_in),
        .cal_const_in(cal_const_in), .cmd_ready_out(ready), .bus_hold_off_out(hold),
        .cfg_load_out(cfg_load), .cfg_data_out(cfg_data), .cfg_channel_out(cfg_ch),
        .cal_start_out(cal_start), .cal_volts_out(volts), .cal_neg_out(cal_neg),
        .key_press_out(key_press), .key_code_out(key_code), .key_digit_out(key_digit),
        .machine_status_word_out(msw), .error_out(err));
    bus_ctrl_model i_bus_ctrl_model (.clk_in(clk_in), .cmd_ready_in(ready),
        .cmd_valid_out(valid), .cmd_char_out(chr));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        if (cfg_load) begin
            n_cfg++;
            l_cfg = cfg_data;
            l_ch = cfg_ch;
        end
        if (cal_start) n_cal++;
        if (hold) n_hold++;
        if (key_press) kq.push_back(key_code);
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input string s);
        i_bus_ctrl_model.send(s);
        repeat (8) @(posedge clk_in);
    endtask
    task automatic t_power_up;
        chk("reset loads", 2, n_cfg);
        chk("reset cfg", 0, l_cfg);
        $display("done power_up");
    endtask
    task automatic t_save_recall;
        channel_in <= 1'b1;
        cur_cfg_in <= 64'h1111_2222_3333_4444;
        cmd("L1X");
        channel_in <= 1'b0;
        cur_cfg_in <= 64'h5555_6666_7777_8888;
        cmd("L2X");
        channel_in <= 1'b1;
        cmd("A1X");
        chk("recall 1", 64'h1111_2222_3333_4444, l_cfg);
        chk("recall ch", 1, l_ch);
        channel_in <= 1'b0;
        cmd("A2X");
        chk("recall 2", 64'h5555_6666_7777_8888, l_cfg);
        cmd("A0X");
        chk("factory", 0, l_cfg);
        cmd("A2X");
        cmd("A1X");
        chk("ch0 slot 1", 0, l_cfg);
        chk("load count", 7, n_cfg);
        $display("done save_recall");
    endtask
    task automatic t_keys;
        cmd("H18XH4X");
        chk("key count", 2, kq.size());
        chk("first key", 8'h12, kq[0]);
        chk("status", 8'h04, msw);
        cmd("H33X");
        chk("digit", 1, key_digit);
        cmd("H9X");
        chk("no press", 3, kq.size());
        chk("no error", 0, err);
        cmd("H39X");
        chk("bad key", 1, err);
        chk("bad key press", 3, kq.size());
        cmd("H30X");
        chk("key with zero digit", 8'h1e, kq[3]);
        cmd("H257X");
        chk("long key press", 4, kq.size());
        $display("done keys");
    endtask
    task automatic t_clear;
        dev_clear_in <= 1'b1;
        @(posedge clk_in);
        dev_clear_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        chk("clear error", 0, err);
        chk("clear loads", 9, n_cfg);
        chk("clear cfg", 64'h1111_2222_3333_4444, l_cfg);
        $display("done clear");
    endtask
    task automatic t_cal;
        logic [63:0] stored;
        cmd("L4,-200X");
        chk("cal start", 1, n_cal);
        chk("cal volts", 16'h00c8, volts);
        chk("cal sign", 1, cal_neg);
        cmd("L4,201X");
        chk("cal refused", 1, n_cal);
        chk("cal error", 1, err);
        channel_in <= 1'b1;
        cal_const_in <= 32'h1234_5678;
        cmd("L5X");
        stored = i_setup_save_recall_keys.nvram_u.mem_q[7];
        chk("cal store", 64'h0000_0000_1234_5678, stored);
        $display("done cal");
    endtask
    task automatic t_hold;
        hold_en <= 1'b0;
        n_hold = 0;
        cmd("A1X");
        chk("no hold off", 0, n_hold);
        hold_en <= 1'b1;
        cmd("A1X");
        chk("hold off cycles", 3, n_hold);
        $display("done hold");
    endtask
    task automatic report_and_stop;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst_b_in = 1'b0;
        dev_clear_in = 1'b0;
        channel_in = 1'b0;
        cur_cfg_in = 64'h0;
        hold_en = 1'b1;
        cal_const_in = 32'h0;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (16) @(posedge clk_in);
        t_power_up();
        t_save_recall();
        t_keys();
        t_clear();
        t_cal();
        t_hold();
        report_and_stop();
    end
endmodule // setup_save_recall_keys_test
`default_nettype wire
